// ==== rtl/ecp_top.sv ====
// External control port: command input decoding, status pin drive and trigger pulse,
// with an AHB-Lite register slave. Assumes trig_request and bus signals are synchronous to clk; command and select pins pass two synchroniser flops.
//
// Decided for this implementation: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps

module ecp_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic pin_output_off_n,
  input wire logic pin_output_on_n,
  input wire logic pin_seq_start_n,
  input wire logic pin_seq_stop_n,
  input wire logic pin_seq_hold_n,
  input wire logic pin_branch1_n,
  input wire logic pin_branch2_n,
  input wire logic pin_recall_n,
  input wire logic pin_mem_sel1,
  input wire logic pin_mem_sel2,
  input wire logic pin_peak_clear_n,
  input wire logic trig_request,
  output logic pin_power_state,
  output logic pin_output_state,
  output logic pin_protect,
  output logic pin_limiter,
  output logic pin_cal_state,
  output logic pin_sw_busy,
  output logic pin_range,
  output logic pin_step_code1,
  output logic pin_step_code2,
  output logic pin_trigger,
  output logic cmd_output_off,
  output logic cmd_output_on,
  output logic cmd_seq_start,
  output logic cmd_seq_stop,
  output logic cmd_seq_hold,
  output logic cmd_branch1,
  output logic cmd_branch2,
  output logic cmd_recall,
  output logic [1:0] recall_index,
  output ecp_pkg::ecp_func_t recall_kind,
  output logic recall_compile,
  output logic cmd_peak_clear,
  output logic companion_link_mode,
  output logic irq
);
  import ecp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [6:0] ctrl_reg;
  logic [15:0] trig_width_reg;
  logic [8:0] state_reg;
  logic [8:0] evt_status_reg;
  logic [8:0] evt_enable_reg;
  logic [1:0] recall_index_reg;
  ecp_func_t recall_kind_reg;
  logic recall_compile_reg;
  logic [31:0] hrdata_reg;

  ecp_mode_t port_mode;
  ecp_func_t active_func;
  logic status_polarity_select;
  logic trig_pol_positive;
  logic remote_active;

  assign port_mode = ecp_mode_t'(ctrl_reg[ECP_CTRL_MODE_LSB +: 2]);
  assign active_func = ecp_func_t'(ctrl_reg[ECP_CTRL_FUNC_LSB +: 2]);
  assign status_polarity_select = ctrl_reg[ECP_CTRL_POL_BIT];
  assign trig_pol_positive = ctrl_reg[ECP_CTRL_TRIG_POL_BIT];
  assign remote_active = ctrl_reg[ECP_CTRL_REMOTE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY

  logic dp_write_reg;
  logic [7:0] dp_addr_reg;
  logic ap_valid;
  logic [7:0] ap_addr;

  assign ap_valid = hsel && htrans[1] && hready;
  assign ap_addr = {haddr[7:2], 2'b00};
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  function automatic logic dp_wr(input logic [7:0] ofs, input logic wr, input logic [7:0] a);
    dp_wr = wr && (a == ofs);
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dp_write_reg <= 1'b0;
      dp_addr_reg <= 8'h00;
    end else begin
      dp_write_reg <= ap_valid && hwrite;
      dp_addr_reg <= ap_addr;
    end
  end

  // Synchronised pin levels, used for readback too
  logic [8:0] edge_sync_q;
  logic [1:0] sel_sync_q;
  logic [31:0] read_mux;

  always_comb begin
    read_mux = 32'h0000_0000;
    case (ap_addr)
      ECP_CTRL_OFS: read_mux[6:0] = ctrl_reg;
      ECP_TRIG_WIDTH_OFS: read_mux[15:0] = trig_width_reg;
      ECP_STATE_OFS: read_mux[8:0] = state_reg;
      ECP_EVT_STATUS_OFS: read_mux[8:0] = evt_status_reg;
      ECP_EVT_ENABLE_OFS: read_mux[8:0] = evt_enable_reg;
      ECP_RECALL_OFS: read_mux[4:0] = {recall_compile_reg, recall_kind_reg, recall_index_reg};
      ECP_PINS_OFS: read_mux[10:0] = {sel_sync_q, edge_sync_q};
      default: read_mux = 32'h0000_0000;
    endcase
  end

  // Read data is latched at the address phase so the data phase sees a flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (ap_valid && !hwrite) begin
      hrdata_reg <= read_mux;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= ECP_CTRL_RESET;
      trig_width_reg <= ECP_TRIG_WIDTH_RESET;
      state_reg <= ECP_STATE_RESET;
      evt_enable_reg <= ECP_EV_RESET;
    end else begin
      if (dp_wr(ECP_CTRL_OFS, dp_write_reg, dp_addr_reg)) begin
        ctrl_reg <= hwdata[6:0];
      end
      if (dp_wr(ECP_TRIG_WIDTH_OFS, dp_write_reg, dp_addr_reg)) begin
        trig_width_reg <= hwdata[15:0];
      end
      if (dp_wr(ECP_STATE_OFS, dp_write_reg, dp_addr_reg)) begin
        state_reg <= hwdata[8:0];
      end
      if (dp_wr(ECP_EVT_ENABLE_OFS, dp_write_reg, dp_addr_reg)) begin
        evt_enable_reg <= hwdata[8:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command inputs

  logic [8:0] edge_pins_n;
  logic [8:0] edge_meta_q;
  logic [8:0] edge_last_q;
  logic [1:0] sel_meta_q;
  logic [8:0] fall_det;
  logic cmd_accept;
  logic [8:0] cmd_fire;

  assign edge_pins_n = {pin_peak_clear_n, pin_recall_n, pin_branch2_n, pin_branch1_n,
                        pin_seq_hold_n, pin_seq_stop_n, pin_seq_start_n, pin_output_on_n,
                        pin_output_off_n};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_meta_q <= 9'h1ff;
      edge_sync_q <= 9'h1ff;
      edge_last_q <= 9'h1ff;
      sel_meta_q <= 2'h0;
      sel_sync_q <= 2'h0;
    end else begin
      edge_meta_q <= edge_pins_n;
      edge_sync_q <= edge_meta_q;
      edge_last_q <= edge_sync_q;
      sel_meta_q <= {pin_mem_sel2, pin_mem_sel1};
      sel_sync_q <= sel_meta_q;
    end
  end

  assign fall_det = edge_last_q & ~edge_sync_q;
  assign cmd_accept = (port_mode == ECP_MODE_ENABLED) && !remote_active;
  assign cmd_fire = cmd_accept ? fall_det : 9'h000;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_output_off <= 1'b0;
      cmd_output_on <= 1'b0;
      cmd_seq_start <= 1'b0;
      cmd_seq_stop <= 1'b0;
      cmd_seq_hold <= 1'b0;
      cmd_branch1 <= 1'b0;
      cmd_branch2 <= 1'b0;
      cmd_recall <= 1'b0;
      cmd_peak_clear <= 1'b0;
    end else begin
      cmd_output_off <= cmd_fire[ECP_EV_OUT_OFF];
      cmd_output_on <= cmd_fire[ECP_EV_OUT_ON];
      cmd_seq_start <= cmd_fire[ECP_EV_SEQ_START];
      cmd_seq_stop <= cmd_fire[ECP_EV_SEQ_STOP];
      cmd_seq_hold <= cmd_fire[ECP_EV_SEQ_HOLD];
      cmd_branch1 <= cmd_fire[ECP_EV_BRANCH1];
      cmd_branch2 <= cmd_fire[ECP_EV_BRANCH2];
      cmd_recall <= cmd_fire[ECP_EV_RECALL];
      cmd_peak_clear <= cmd_fire[ECP_EV_PEAK_CLR];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      recall_index_reg <= 2'h0;
      recall_kind_reg <= ECP_FUNC_CONTINUOUS;
      recall_compile_reg <= 1'b0;
    end else if (cmd_fire[ECP_EV_RECALL]) begin
      recall_index_reg <= sel_sync_q;
      recall_kind_reg <= active_func;
      recall_compile_reg <= (active_func == ECP_FUNC_SEQUENCE) ||
                            (active_func == ECP_FUNC_SIMULATION);
    end
  end

  assign recall_index = recall_index_reg;
  assign recall_kind = recall_kind_reg;
  assign recall_compile = recall_compile_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Event status, clear and interrupt

  logic [8:0] evt_clear;

  assign evt_clear = dp_wr(ECP_EVT_CLEAR_OFS, dp_write_reg, dp_addr_reg) ? hwdata[8:0] : 9'h000;

  // A new event in the clear cycle survives the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_status_reg <= ECP_EV_RESET;
    end else begin
      evt_status_reg <= (evt_status_reg & ~evt_clear) | cmd_fire;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |((evt_status_reg & ~evt_clear | cmd_fire) & evt_enable_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger pulse

  ecp_trg_state_t trg_state;
  logic [15:0] trg_count;
  logic trg_fire;
  logic [15:0] trg_len;

  assign trg_fire = trig_request || (dp_wr(ECP_TRIG_FIRE_OFS, dp_write_reg, dp_addr_reg) && hwdata[0]);
  // A zero width would wrap the counter to a 65536-cycle pulse, so it counts as one cycle
  assign trg_len = (trig_width_reg == 16'h0000) ? 16'h0001 : trig_width_reg;

  // width counter; a request during a pulse is dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trg_state <= ECP_TRG_IDLE;
      trg_count <= 16'h0000;
    end else begin
      case (trg_state)
        ECP_TRG_IDLE: begin
          if (trg_fire && port_mode != ECP_MODE_LINK) begin
            trg_state <= ECP_TRG_PULSE;
            trg_count <= trg_len - 16'h0001;
          end
        end
        ECP_TRG_PULSE: begin
          if (trg_count == 16'h0000) begin
            trg_state <= ECP_TRG_IDLE;
          end else begin
            trg_count <= trg_count - 16'h0001;
          end
        end
        default: begin
          trg_state <= ECP_TRG_IDLE;
          trg_count <= 16'h0000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status pins

  logic link_active;
  logic inv_n;

  assign link_active = (port_mode == ECP_MODE_LINK);
  // Negative polarity drives the active sense low
  assign inv_n = !status_polarity_select;

  // pins held low in link mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_power_state <= 1'b0;
      pin_output_state <= 1'b1;
      pin_protect <= 1'b1;
      pin_limiter <= 1'b1;
      pin_cal_state <= 1'b1;
      pin_sw_busy <= 1'b1;
      pin_range <= 1'b0;
      pin_step_code1 <= 1'b0;
      pin_step_code2 <= 1'b0;
      // Idle level of the negative trigger polarity that CTRL resets to, so no false pulse edge
      pin_trigger <= 1'b1;
      companion_link_mode <= 1'b0;
    end else if (link_active) begin
      pin_power_state <= 1'b0;
      pin_output_state <= 1'b0;
      pin_protect <= 1'b0;
      pin_limiter <= 1'b0;
      pin_cal_state <= 1'b0;
      pin_sw_busy <= 1'b0;
      pin_range <= 1'b0;
      pin_step_code1 <= 1'b0;
      pin_step_code2 <= 1'b0;
      pin_trigger <= 1'b0;
      companion_link_mode <= 1'b1;
    end else begin
      pin_power_state <= state_reg[ECP_ST_POWER_BIT];
      pin_range <= state_reg[ECP_ST_RANGE100_BIT];
      pin_output_state <= state_reg[ECP_ST_OUTPUT_BIT] ^ inv_n;
      pin_cal_state <= state_reg[ECP_ST_CAL_BIT] ^ inv_n;
      pin_protect <= state_reg[ECP_ST_PROTECT_BIT] ^ inv_n;
      pin_limiter <= state_reg[ECP_ST_LIMITER_BIT] ^ inv_n;
      pin_sw_busy <= state_reg[ECP_ST_BUSY_BIT] ^ inv_n;
      pin_step_code1 <= state_reg[ECP_ST_STEP_LSB];
      pin_step_code2 <= state_reg[ECP_ST_STEP_LSB + 1];
      pin_trigger <= (trg_state == ECP_TRG_PULSE) ~^ trig_pol_positive;
      companion_link_mode <= 1'b0;
    end
  end

endmodule

// ==== rtl/ecp_pkg.sv ====
// Constants and types shared by the external control port logic.
// Assumes a single 40 MHz system clock and a 32-bit AHB-Lite register bus.
package ecp_pkg;

  // Register byte offsets
  localparam logic [7:0] ECP_CTRL_OFS = 8'h00;
  localparam logic [7:0] ECP_TRIG_WIDTH_OFS = 8'h04;
  localparam logic [7:0] ECP_STATE_OFS = 8'h08;
  localparam logic [7:0] ECP_TRIG_FIRE_OFS = 8'h0c;
  localparam logic [7:0] ECP_EVT_STATUS_OFS = 8'h10;
  localparam logic [7:0] ECP_EVT_CLEAR_OFS = 8'h14;
  localparam logic [7:0] ECP_EVT_ENABLE_OFS = 8'h18;
  localparam logic [7:0] ECP_RECALL_OFS = 8'h1c;
  localparam logic [7:0] ECP_PINS_OFS = 8'h20;

  // Control register fields
  localparam int ECP_CTRL_MODE_LSB = 0;
  localparam int ECP_CTRL_POL_BIT = 2;
  localparam int ECP_CTRL_TRIG_POL_BIT = 3;
  localparam int ECP_CTRL_REMOTE_BIT = 4;
  localparam int ECP_CTRL_FUNC_LSB = 5;
  localparam logic [6:0] ECP_CTRL_RESET = 7'h00;

  // State register fields
  localparam int ECP_ST_OUTPUT_BIT = 0;
  localparam int ECP_ST_PROTECT_BIT = 1;
  localparam int ECP_ST_LIMITER_BIT = 2;
  localparam int ECP_ST_CAL_BIT = 3;
  localparam int ECP_ST_BUSY_BIT = 4;
  localparam int ECP_ST_POWER_BIT = 5;
  localparam int ECP_ST_RANGE100_BIT = 6;
  localparam int ECP_ST_STEP_LSB = 7;
  localparam logic [8:0] ECP_STATE_RESET = 9'h000;

  // Trigger width in clock cycles
  localparam logic [15:0] ECP_TRIG_WIDTH_RESET = 16'h0001;

  // Command event bit positions (status, clear, enable share the layout)
  localparam int ECP_EV_OUT_OFF = 0;
  localparam int ECP_EV_OUT_ON = 1;
  localparam int ECP_EV_SEQ_START = 2;
  localparam int ECP_EV_SEQ_STOP = 3;
  localparam int ECP_EV_SEQ_HOLD = 4;
  localparam int ECP_EV_BRANCH1 = 5;
  localparam int ECP_EV_BRANCH2 = 6;
  localparam int ECP_EV_RECALL = 7;
  localparam int ECP_EV_PEAK_CLR = 8;
  localparam int ECP_NUM_EV = 9;
  localparam logic [8:0] ECP_EV_RESET = 9'h000;

  typedef enum logic [1:0] {
    ECP_MODE_DISABLED = 2'h0,
    ECP_MODE_ENABLED = 2'h1,
    ECP_MODE_LINK = 2'h2
  } ecp_mode_t;

  typedef enum logic [1:0] {
    ECP_FUNC_CONTINUOUS = 2'h0,
    ECP_FUNC_SEQUENCE = 2'h1,
    ECP_FUNC_SIMULATION = 2'h2
  } ecp_func_t;

  typedef enum logic [1:0] {
    ECP_TRG_IDLE = 2'h0,
    ECP_TRG_PULSE = 2'h1
  } ecp_trg_state_t;

endpackage

// ==== dv/ecp_props.sv ====
// Checker for the external control port, bound to ecp_top.
// Assumes one clock domain and the top module's port names.
`timescale 1ns/1ps
module ecp_props
  import ecp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin_output_on_n,
  input wire logic pin_branch1_n,
  input wire logic pin_peak_clear_n,
  input wire logic pin_mem_sel1,
  input wire logic pin_mem_sel2,
  input wire logic cmd_output_on,
  input wire logic cmd_branch1,
  input wire logic cmd_peak_clear,
  input wire logic cmd_recall,
  input wire logic [1:0] recall_index,
  input wire ecp_pkg::ecp_func_t recall_kind,
  input wire logic recall_compile,
  input wire logic companion_link_mode,
  input wire logic pin_output_state,
  input wire logic pin_power_state
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////
  chk_cmd_one_pulse: assert property (
    cmd_output_on |=> !cmd_output_on) else $error("command pulse longer than one cycle");
  chk_on_after_fall: assert property (
    cmd_output_on |-> !$past(pin_output_on_n, 3) && $past(pin_output_on_n, 4))
    else $error("output on command without a falling edge");
  chk_branch_fall: assert property (
    cmd_branch1 |-> !$past(pin_branch1_n, 3) && $past(pin_branch1_n, 4))
    else $error("branch command without a falling edge");
  chk_peak_fall: assert property (
    cmd_peak_clear |-> !$past(pin_peak_clear_n, 3) && $past(pin_peak_clear_n, 4))
    else $error("peak clear without a falling edge");
  chk_recall_index: assert property (
    cmd_recall |-> recall_index == {$past(pin_mem_sel2, 3), $past(pin_mem_sel1, 3)})
    else $error("recall index differs from select pins");
  chk_recall_compile: assert property (
    cmd_recall |-> recall_compile == (recall_kind inside {ECP_FUNC_SEQUENCE, ECP_FUNC_SIMULATION}))
    else $error("compile request does not follow memory kind");
  chk_recall_hold: assert property (
    !cmd_recall |-> $stable(recall_index) && $stable(recall_kind) && $stable(recall_compile))
    else $error("recall target changed without a recall command");
  chk_link_no_cmd: assert property (
    companion_link_mode && $past(companion_link_mode) |-> !cmd_output_on && !cmd_recall)
    else $error("command decoded in link mode");
  chk_link_pins: assert property (
    companion_link_mode && $past(companion_link_mode) |-> !pin_output_state && !pin_power_state)
    else $error("status pins driven in link mode");
endmodule

// ==== dv/ecp_ctl_model.sv ====
// Model of the external controller that pulls the command pins.
// Assumes the bench pulses go with a pin index in command bit order.
`timescale 1ns/1ps
module ecp_ctl_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [3:0] idx,
  input wire logic [1:0] sel,
  output logic [8:0] pins_n,
  output logic sel1,
  output logic sel2
);
  logic [1:0] low_reg;
  logic [3:0] idx_reg;
  //////////////////////////////////////////
  // lines idle high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_reg <= 2'h0;
      idx_reg <= 4'h0;
    end else if (go) begin
      low_reg <= 2'h3;
      idx_reg <= idx;
    end else if (low_reg != 2'h0) begin
      low_reg <= low_reg - 2'h1;
    end
  end
  // Held low three cycles so the port sees a clean edge
  assign pins_n = (low_reg != 2'h0) ? ~(9'h001 << idx_reg) : 9'h1ff;
  assign sel1 = sel[0];
  assign sel2 = sel[1];
endmodule

// ==== dv/tb.sv ====
// Testbench for ecp_top: AHB-Lite register access and command pin traffic.
// Assumes the controller model and the checker file are compiled first.
`timescale 1ns/1ps
module tb;
  import ecp_pkg::*;
  logic clk, rst_n, hsel, hwrite, go, trig_request, hreadyout, hresp, sel1, sel2, irq, link, trg, rcomp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, sel, ridx;
  logic [2:0] hsize;
  logic [3:0] idx;
  logic [8:0] pins_n, cmd_vec, st, s;
  ecp_func_t rkind;
  int hits[9];
  int miscompares, compares, n;
  //////////////////////////////////////////
  ecp_top i_ecp_top (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pin_output_off_n(pins_n[0]), .pin_output_on_n(pins_n[1]),
    .pin_seq_start_n(pins_n[2]), .pin_seq_stop_n(pins_n[3]), .pin_seq_hold_n(pins_n[4]),
    .pin_branch1_n(pins_n[5]), .pin_branch2_n(pins_n[6]), .pin_recall_n(pins_n[7]),
    .pin_mem_sel1(sel1), .pin_mem_sel2(sel2), .pin_peak_clear_n(pins_n[8]), .trig_request(trig_request),
    .pin_power_state(st[5]), .pin_output_state(st[0]), .pin_protect(st[1]), .pin_limiter(st[2]),
    .pin_cal_state(st[3]), .pin_sw_busy(st[4]), .pin_range(st[6]), .pin_step_code1(st[7]),
    .pin_step_code2(st[8]), .pin_trigger(trg), .cmd_output_off(cmd_vec[0]), .cmd_output_on(cmd_vec[1]),
    .cmd_seq_start(cmd_vec[2]), .cmd_seq_stop(cmd_vec[3]), .cmd_seq_hold(cmd_vec[4]),
    .cmd_branch1(cmd_vec[5]), .cmd_branch2(cmd_vec[6]), .cmd_recall(cmd_vec[7]), .recall_index(ridx),
    .recall_kind(rkind), .recall_compile(rcomp), .cmd_peak_clear(cmd_vec[8]),
    .companion_link_mode(link), .irq(irq));
  ecp_ctl_model i_ecp_ctl_model (.clk(clk), .rst_n(rst_n), .go(go), .idx(idx), .sel(sel),
    .pins_n(pins_n), .sel1(sel1), .sel2(sel2));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    for (int i = 0; i < 9; i++) if (cmd_vec[i] === 1'b1) hits[i]++;
  end
  //////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict;
    if (miscompares == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 20);
    if (hreadyout !== 1'b1) begin
      miscompares++;
      give_verdict;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask
  task automatic press(input int i);
    @(posedge clk);
    go <= 1'b1;
    idx <= 4'(i);
    @(posedge clk);
    go <= 1'b0;
    repeat (10) @(posedge clk);
  endtask
  task automatic count_trig(input logic lvl, input int exp);
    n = 0;
    repeat (14) @(negedge clk) if (trg === lvl) n++;
    check("trigger width", n, exp);
  endtask
  //////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = '0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    go = 1'b0;
    idx = '0;
    sel = '0;
    trig_request = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    bus(0, ECP_CTRL_OFS, 0);
    check("ctrl reset", rd, 0);
    bus(0, ECP_TRIG_WIDTH_OFS, 0);
    check("width reset", rd, 1);
    bus(0, 8'h3c, 0);
    check("unmapped", rd, 0);
    check("bus response", hresp, 0);
    check("status pins reset", st, 9'h01f);
    press(1);
    check("disabled on", hits[1], 0);
    bus(1, ECP_CTRL_OFS, 1);
    bus(1, ECP_EVT_ENABLE_OFS, 32'h1ff);
    for (int i = 0; i < 9; i++) begin
      press(i);
      check("command count", hits[i], 1);
    end
    bus(0, ECP_EVT_STATUS_OFS, 0);
    check("event status", rd, 32'h1ff);
    check("irq set", irq, 1);
    bus(1, ECP_EVT_CLEAR_OFS, 32'h1ff);
    bus(0, ECP_EVT_STATUS_OFS, 0);
    check("status cleared", rd, 0);
    bus(1, ECP_EVT_ENABLE_OFS, 0);
    press(8);
    check("peak clear", hits[8], 2);
    check("irq masked", irq, 0);
    bus(1, ECP_CTRL_OFS, 32'h11);
    press(0);
    check("remote ignore", hits[0], 1);
    for (int f = 0; f < 3; f++) for (int m = 0; m < 4; m++) begin
      sel <= 2'(m);
      bus(1, ECP_CTRL_OFS, 32'h1 | (f << 5));
      press(7);
      bus(0, ECP_RECALL_OFS, 0);
      check("recall", rd, {(f != 0), 2'(f), 2'(m)});
      check("recall index", ridx, m);
      check("recall kind", rkind, f);
      check("recall compile", rcomp, f != 0);
    end
    bus(0, ECP_PINS_OFS, 0);
    check("pin levels", rd, 32'h7ff);
    for (int p = 0; p < 2; p++) for (int k = 0; k < 2; k++) begin
      s = k ? 9'h14a : 9'h0b5;
      // Status only: port left disabled so stray edges cannot command
      bus(1, ECP_CTRL_OFS, p << 2);
      bus(1, ECP_STATE_OFS, s);
      repeat (2) @(negedge clk);
      check("status pins", st, p ? s : {s[8:5], ~s[4:0]});
    end
    bus(1, ECP_CTRL_OFS, 2);
    repeat (2) @(negedge clk);
    check("link flag", link, 1);
    press(1);
    check("link ignore", hits[1], 1);
    bus(1, ECP_CTRL_OFS, 32'h9);
    bus(1, ECP_TRIG_WIDTH_OFS, 3);
    bus(1, ECP_TRIG_FIRE_OFS, 1);
    count_trig(1'b1, 3);
    bus(1, ECP_CTRL_OFS, 1);
    bus(1, ECP_TRIG_WIDTH_OFS, 5);
    @(posedge clk);
    trig_request <= 1'b1;
    @(posedge clk);
    trig_request <= 1'b0;
    count_trig(1'b0, 5);
    // Reset in mid-run: sticky status, control and pins must return to their reset values
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    check("status pins again", st, 9'h01f);
    check("trigger idle", trg, 1);
    rst_n <= 1'b1;
    bus(0, ECP_EVT_STATUS_OFS, 0);
    check("status after reset", rd, 0);
    bus(0, ECP_CTRL_OFS, 0);
    check("ctrl after reset", rd, 0);
    give_verdict;
  end
endmodule
bind ecp_top ecp_props i_ecp_props (.clk(clk), .rst_n(rst_n), .pin_output_on_n(pin_output_on_n),
  .pin_branch1_n(pin_branch1_n), .pin_peak_clear_n(pin_peak_clear_n), .pin_mem_sel1(pin_mem_sel1),
  .pin_mem_sel2(pin_mem_sel2), .cmd_output_on(cmd_output_on), .cmd_branch1(cmd_branch1),
  .cmd_peak_clear(cmd_peak_clear), .cmd_recall(cmd_recall), .recall_index(recall_index),
  .recall_kind(recall_kind), .recall_compile(recall_compile), .companion_link_mode(companion_link_mode),
  .pin_output_state(pin_output_state), .pin_power_state(pin_power_state));
